// *** rtl/kbs_scanner.sv ***
// Keyboard matrix scanner: drives rows low one at a time, reads columns through a mux.
// Assumes column lines are pulled up outside and all inputs are synchronous to clk.
//
// Overview of operation
// - Start a complete matrix scan every 8 ms while idle.
// - A single settled key is reported as a code with a one-cycle strobe.
// - After a press is seen, wait 8 ms before confirming the key.
// - While the key is held, no other key is accepted.
// - Release of the held key starts an 8 ms break debounce.
// - After break debounce, return to periodic 8 ms scanning.
// - Each scan samples every row and column intersection.
// - Two or more keys in one scan are discarded; none is reported.
// - Only one row is driven, to zero; other rows are left floating.
// - Columns read through a 2:1 mux; a low column means a closed switch.
`timescale 1ns/10ps
module kbs_scanner #(
    parameter int unsigned TIMEBASE_CYC = kbs_pkg::INTERVAL_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Row pins, open drain
    input wire logic [7:0] row_in,
    output logic [7:0] row_out,
    output logic [7:0] row_oe,
    // Column mux
    input wire logic [7:0] col_in,
    output logic col_sel,
    // Key events to the terminal controller
    output logic key_valid,
    output logic [6:0] key_code,
    output logic scan_reject,
    output logic key_locked
);

    kbs_pkg::kbs_state_t state;
    kbs_pkg::kbs_state_t next_state;
    kbs_pkg::kbs_kind_t kind;
    kbs_pkg::kbs_kind_t next_kind;
    logic tmr_restart;
    logic tmr_exp;
    logic [3:0] pos;
    logic [3:0] next_pos;
    logic [7:0] settle;
    logic [1:0] hits;
    logic [6:0] first_code;
    logic [6:0] held_code;
    logic held_seen;
    logic [3:0] zeros;
    logic [4:0] hit_sum;
    logic [19:0] dwell;
    logic [7:0] row_echo;

    // Closed switches pull a column low.
    function automatic logic [3:0] count_closed(input logic [7:0] cols);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < kbs_pkg::COL_PORT_W; i++) begin
            n = n + {3'h0, ~cols[i]};
        end
        return n;
    endfunction

    function automatic logic [2:0] first_closed(input logic [7:0] cols);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = kbs_pkg::COL_PORT_W - 1; i >= 0; i--) begin
            if (!cols[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    kbs_interval_timer #(
        .PERIOD_CYC(TIMEBASE_CYC)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .restart(tmr_restart),
        .expired(tmr_exp)
    );

    always_comb begin
        next_state = state;
        next_kind = kind;
        unique case (state)
            kbs_pkg::ST_IDLE: begin
                if (tmr_exp) begin
                    next_state = kbs_pkg::ST_SCAN;
                    next_kind = kbs_pkg::SK_NEW;
                end
            end
            kbs_pkg::ST_SCAN: begin
                if (settle == 8'h00 && pos == kbs_pkg::LAST_POS) begin
                    next_state = kbs_pkg::ST_EVAL;
                end
            end
            kbs_pkg::ST_EVAL: begin
                unique case (kind)
                    kbs_pkg::SK_NEW: begin
                        // A lone closure arms the make debounce; none or several go back.
                        next_state = (hits == 2'h1) ? kbs_pkg::ST_MAKE : kbs_pkg::ST_IDLE;
                    end
                    kbs_pkg::SK_CONFIRM: begin
                        next_state = held_seen ? kbs_pkg::ST_HELD : kbs_pkg::ST_IDLE;
                    end
                    kbs_pkg::SK_HOLD: begin
                        next_state = held_seen ? kbs_pkg::ST_HELD : kbs_pkg::ST_BREAK;
                    end
                    default: begin
                        next_state = kbs_pkg::ST_IDLE;
                    end
                endcase
            end
            kbs_pkg::ST_MAKE: begin
                if (tmr_exp) begin
                    next_state = kbs_pkg::ST_SCAN;
                    next_kind = kbs_pkg::SK_CONFIRM;
                end
            end
            kbs_pkg::ST_HELD: begin
                if (tmr_exp) begin
                    next_state = kbs_pkg::ST_SCAN;
                    next_kind = kbs_pkg::SK_HOLD;
                end
            end
            kbs_pkg::ST_BREAK: begin
                if (tmr_exp) begin
                    next_state = kbs_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Debounce intervals are measured from their own start, not from the free-running tick.
    assign tmr_restart = (state == kbs_pkg::ST_EVAL)
        && (next_state == kbs_pkg::ST_MAKE || next_state == kbs_pkg::ST_BREAK);

    assign zeros = count_closed(col_in);
    assign hit_sum = {3'h0, hits} + {1'b0, zeros};
    assign next_pos = pos + 4'h1;

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= kbs_pkg::ST_IDLE;
            kind <= kbs_pkg::SK_NEW;
        end else begin
            state <= next_state;
            kind <= next_kind;
        end
    end

    // Scan sequencer: one row low at a time, two mux halves per row.
    always_ff @(posedge clk) begin
        if (reset) begin
            pos <= 4'h0;
            settle <= 8'h00;
            row_oe <= 8'h00;
            col_sel <= 1'b0;
        end else if (state != kbs_pkg::ST_SCAN && next_state == kbs_pkg::ST_SCAN) begin
            pos <= 4'h0;
            settle <= kbs_pkg::SETTLE_LOAD;
            row_oe <= kbs_pkg::ROW_FIRST;
            col_sel <= 1'b0;
        end else if (state == kbs_pkg::ST_SCAN) begin
            if (settle != 8'h00) begin
                settle <= settle - 8'h01;
            end else if (pos != kbs_pkg::LAST_POS) begin
                pos <= next_pos;
                settle <= kbs_pkg::SETTLE_LOAD;
                row_oe <= kbs_pkg::ROW_FIRST << next_pos[3:1];
                col_sel <= next_pos[0];
            end else begin
                // The mux stays on its last half; the next scan start reselects half 0
                // under a fresh settle, so no column is ever read across a mux change.
                row_oe <= 8'h00;
            end
        end
    end

    // Rows are only ever pulled low; release is by dropping the enable.
    always_ff @(posedge clk) begin
        if (reset) begin
            row_out <= 8'h00;
            row_echo <= 8'h00;
        end else begin
            row_out <= 8'h00;
            row_echo <= row_in;
        end
    end

    // Closure accumulation; the count saturates at two since more adds nothing.
    always_ff @(posedge clk) begin
        if (reset) begin
            hits <= 2'h0;
            first_code <= 7'h00;
            held_seen <= 1'b0;
        end else if (state != kbs_pkg::ST_SCAN && next_state == kbs_pkg::ST_SCAN) begin
            hits <= 2'h0;
            held_seen <= 1'b0;
        end else if (state == kbs_pkg::ST_SCAN && settle == 8'h00) begin
            hits <= (hit_sum >= 5'h02) ? 2'h2 : hit_sum[1:0];
            if (hits == 2'h0 && zeros != 4'h0) begin
                first_code <= {pos, first_closed(col_in)};
            end
            if (pos == held_code[6:3] && !col_in[held_code[2:0]]) begin
                held_seen <= 1'b1;
            end
        end
    end

    // Key reporting: a key is reported once, after its make debounce confirms it alone.
    always_ff @(posedge clk) begin
        if (reset) begin
            held_code <= 7'h00;
            key_code <= 7'h00;
            key_valid <= 1'b0;
            scan_reject <= 1'b0;
            key_locked <= 1'b0;
        end else begin
            key_valid <= 1'b0;
            scan_reject <= 1'b0;
            // The lock also spans the confirm and hold scans, not only the waits between
            // them, so the controller sees one unbroken span from press to end of break.
            key_locked <= (next_state == kbs_pkg::ST_MAKE) || (next_state == kbs_pkg::ST_HELD)
                || (next_state == kbs_pkg::ST_BREAK)
                || ((next_state == kbs_pkg::ST_SCAN || next_state == kbs_pkg::ST_EVAL)
                && next_kind != kbs_pkg::SK_NEW);
            if (state == kbs_pkg::ST_EVAL) begin
                if (kind == kbs_pkg::SK_NEW && hits == 2'h1) begin
                    held_code <= first_code;
                end
                if (kind != kbs_pkg::SK_HOLD && hits == 2'h2) begin
                    scan_reject <= 1'b1;
                end
                if (kind == kbs_pkg::SK_CONFIRM && held_seen && hits == 2'h1) begin
                    key_valid <= 1'b1;
                    key_code <= held_code;
                end
            end
        end
    end

    // Time spent in the current state; read only by the checks below.
    always_ff @(posedge clk) begin
        if (reset || state != next_state) begin
            dwell <= 20'h00000;
        end else begin
            dwell <= dwell + 20'h00001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_rows_onehot: assert property ($onehot0(row_oe) && row_out == 8'h00)
        else $error("more than one row driven or a row driven high");
    a_rows_idle: assert property (state != kbs_pkg::ST_SCAN |=> row_oe == 8'h00 || $past(next_state) == kbs_pkg::ST_SCAN)
        else $error("row driven outside a scan");
    a_period_start: assert property (state == kbs_pkg::ST_IDLE && tmr_exp |=> state == kbs_pkg::ST_SCAN && kind == kbs_pkg::SK_NEW)
        else $error("periodic scan did not start on the tick");
    a_scan_complete: assert property ($rose(state == kbs_pkg::ST_EVAL) |-> $past(pos) == kbs_pkg::LAST_POS)
        else $error("scan evaluated before the last position");
    a_settle_wait: assert property ($changed(row_oe) && row_oe != 8'h00 || $changed(col_sel) |-> settle == kbs_pkg::SETTLE_LOAD)
        else $error("columns not given time to settle");
    a_key_single: assert property (key_valid |-> hits == 2'h1 && key_code == held_code && $past(kind) == kbs_pkg::SK_CONFIRM)
        else $error("key reported without a single confirmed closure");
    a_multi_drop: assert property (state == kbs_pkg::ST_EVAL && kind == kbs_pkg::SK_NEW && hits == 2'h2 |=> state == kbs_pkg::ST_IDLE && scan_reject && !key_valid)
        else $error("simultaneous keys not discarded");
    a_make_time: assert property (state == kbs_pkg::ST_MAKE && next_state != kbs_pkg::ST_MAKE |-> dwell == 20'(TIMEBASE_CYC))
        else $error("make debounce length wrong");
    a_hold_lock: assert property (state == kbs_pkg::ST_HELD |=> !key_valid)
        else $error("new key accepted while a key is held");
    a_break_start: assert property (state == kbs_pkg::ST_EVAL && kind == kbs_pkg::SK_HOLD && !held_seen |=> state == kbs_pkg::ST_BREAK ##1 key_locked)
        else $error("release did not start break debounce");
    a_break_time: assert property (state == kbs_pkg::ST_BREAK && next_state != kbs_pkg::ST_BREAK |-> dwell == 20'(TIMEBASE_CYC) ##1 state == kbs_pkg::ST_IDLE)
        else $error("break debounce length or exit wrong");
    a_col_read: assert property (state == kbs_pkg::ST_SCAN && settle == 8'h00 && col_in == 8'hff |=> hits == $past(hits))
        else $error("open columns counted as closures");
    a_row_select: assert property (state == kbs_pkg::ST_SCAN |-> row_oe == (kbs_pkg::ROW_FIRST << pos[3:1]) && col_sel == pos[0])
        else $error("driven row or mux half does not match the scan position");
    a_lock_through: assert property (state == kbs_pkg::ST_HELD && next_state == kbs_pkg::ST_SCAN |=> key_locked)
        else $error("lock dropped during a hold scan");
    a_lock_release: assert property ($fell(key_locked) |-> state == kbs_pkg::ST_IDLE)
        else $error("lock released outside idle");
    a_reject_scope: assert property (scan_reject |-> $past(state) == kbs_pkg::ST_EVAL && $past(kind) != kbs_pkg::SK_HOLD)
        else $error("reject pulse outside a new or confirm evaluation");
    a_valid_pulse: assert property (key_valid |=> !key_valid)
        else $error("key strobe longer than one cycle");
    a_hold_rescan: assert property (state == kbs_pkg::ST_HELD && tmr_exp |=> state == kbs_pkg::ST_SCAN && kind == kbs_pkg::SK_HOLD)
        else $error("held key not rescanned on the tick");

    // Main scenarios.
    c_key_accepted: cover property (key_valid);
    c_multi_reject: cover property (scan_reject);
    c_break_done: cover property (state == kbs_pkg::ST_BREAK ##1 state == kbs_pkg::ST_IDLE);
    c_row_echo: cover property (row_echo != 8'hff);
    c_held_extra: cover property (state == kbs_pkg::ST_EVAL && kind == kbs_pkg::SK_HOLD && hits == 2'h2);

endmodule

// *** shared/kbs_pkg.sv ***
// Constants and types shared by the keyboard matrix scanner.
// Assumes a 100 MHz clock and a matrix of 8 rows by 16 columns read through a 2:1 column mux.
package kbs_pkg;

    localparam int ROWS = 8;
    localparam int COL_PORT_W = 8;
    localparam int POS_W = 4;
    localparam int CODE_W = 7;
    localparam logic [3:0] LAST_POS = 4'hf;
    localparam logic [7:0] ROW_FIRST = 8'h01;

    localparam int CLK_PERIOD_NS = 10;
    // Scan period and both debounce intervals share this figure and one timer.
    localparam int INTERVAL_MS = 8;
    localparam int INTERVAL_CYC = INTERVAL_MS * 1000000 / CLK_PERIOD_NS;

    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SCAN,
        ST_EVAL,
        ST_MAKE,
        ST_HELD,
        ST_BREAK
    } kbs_state_t;

    typedef enum logic [1:0] {
        SK_NEW,
        SK_CONFIRM,
        SK_HOLD
    } kbs_kind_t;

endpackage

// *** rtl/kbs_interval_timer.sv ***
// Free-running interval timer that gives a one-cycle pulse at the end of each period.
// Assumes restart is a one-cycle request from the scanner; it realigns the period.
`timescale 1ns/10ps
module kbs_interval_timer #(
    parameter int unsigned PERIOD_CYC = 800000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic restart,
    output logic expired
);

    localparam int CNT_W = $clog2(PERIOD_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYC - 1);

    logic [CNT_W-1:0] count;

    always_ff @(posedge clk) begin
        if (reset || restart) begin
            count <= '0;
            expired <= 1'b0;
        end else if (count == CNT_LAST) begin
            count <= '0;
            expired <= 1'b1;
        end else begin
            count <= count + 1'b1;
            expired <= 1'b0;
        end
    end

endmodule

// *** dv/kbs_matrix_model.sv ***
// Behavioural switch matrix of 8 rows by 16 columns seen through the 2:1 column mux.
// Assumes rows are pulled low by row_oe and that keys holds one bit per matrix position.
`timescale 1ns/10ps
module kbs_matrix_model (
    // Scanner side
    input wire logic [7:0] row_oe,
    input wire logic col_sel,
    // Switch state, bit index is row*16 + half*8 + column
    input wire logic [127:0] keys,
    // Column port
    output logic [7:0] col_in
);
    always_comb begin
        // Pull-ups make every open column read one.
        col_in = 8'hff;
        for (int r = 0; r < 8; r++) begin
            for (int c = 0; c < 8; c++) begin
                if (row_oe[r] && keys[r * 16 + (col_sel ? 8 : 0) + c]) begin
                    col_in[c] = 1'b0;
                end
            end
        end
    end
endmodule

// *** dv/keyboard_matrix_scanner_bench.sv ***
// Self-checking bench for the keyboard matrix scanner with a shortened timebase.
// Assumes the matrix model in the same folder and the scanner's hand-over timing.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module keyboard_matrix_scanner_bench;
    localparam int TB = 4000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] row_in, row_out, row_oe, col_in;
    logic col_sel, key_valid, scan_reject, key_locked;
    logic [6:0] key_code, last_code = 7'h00;
    logic [127:0] keys = 128'h0;
    logic [31:0] seed = 32'h467c;
    logic [7:0] prev_oe = 8'h00;
    int n_mismatch = 0, n_checks = 0, cyc = 0, n_ev = 0, n_rej = 0, st_a = 0, st_b = 0;

    always #5 clk = ~clk;
    // Open-drain rows: the wire is pulled up unless a row is driven.
    assign row_in = (row_out & row_oe) | ~row_oe;

    kbs_scanner #(.TIMEBASE_CYC(TB)) dut (.clk(clk), .reset(reset), .row_in(row_in),
        .row_out(row_out), .row_oe(row_oe), .col_in(col_in), .col_sel(col_sel),
        .key_valid(key_valid), .key_code(key_code), .scan_reject(scan_reject),
        .key_locked(key_locked));
    kbs_matrix_model matrix (.row_oe(row_oe), .col_sel(col_sel), .keys(keys), .col_in(col_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    always @(posedge clk) begin
        cyc++;
        if (key_valid === 1'b1) begin
            n_ev++;
            last_code = key_code;
        end
        if (scan_reject === 1'b1) n_rej++;
        if (row_oe === 8'h01 && prev_oe === 8'h00) begin
            st_a = st_b;
            st_b = cyc;
        end
        prev_oe = row_oe;
        if (!reset) begin
            `CHK("row one hot", 1'b1, $onehot0(row_oe))
            `CHK("row level", 8'h00, row_out)
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Press one key, optionally add a second key while it is held, then release both.
    task automatic press_release(input logic [6:0] code, input logic [6:0] other, input bit lock);
        int e0, t0;
        e0 = n_ev;
        @(posedge clk) keys <= 128'h1 << code;
        t0 = cyc;
        for (int i = 0; i < 4 * TB && n_ev == e0; i++) @(posedge clk);
        `CHK("key event", e0 + 1, n_ev)
        `CHK("key code", code, last_code)
        `CHK("make delay", 1'b1, (cyc - t0) > TB)
        @(negedge clk);
        `CHK("locked held", 1'b1, key_locked)
        if (lock) begin
            @(posedge clk) keys <= keys | (128'h1 << other);
            repeat (2 * TB) @(posedge clk);
            `CHK("lockout", e0 + 1, n_ev)
        end
        @(posedge clk) keys <= 128'h0;
        t0 = cyc;
        for (int i = 0; i < 4 * TB && key_locked !== 1'b0; i++) @(posedge clk);
        `CHK("unlocked", 1'b0, key_locked)
        `CHK("break delay", 1'b1, (cyc - t0) > TB)
        `CHK("no extra key", e0 + 1, n_ev)
        $display("test key %0h done", code);
    endtask

    initial begin
        int e0, r0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 3 * TB && st_a == 0; i++) @(posedge clk);
        `CHK("scan period", TB, st_b - st_a)
        $display("test period done");
        e0 = n_ev;
        r0 = n_rej;
        @(posedge clk) keys <= (128'h1 << 0) | (128'h1 << 127);
        for (int i = 0; i < 3 * TB && n_rej == r0; i++) @(posedge clk);
        `CHK("reject pulse", r0 + 1, n_rej)
        repeat (4) @(posedge clk);
        `CHK("reject no key", e0, n_ev)
        `CHK("reject unlocked", 1'b0, key_locked)
        @(posedge clk) keys <= 128'h0;
        repeat (TB) @(posedge clk);
        $display("test reject done");
        press_release(7'h00, 7'h7f, 1'b1);
        press_release(7'h7f, 7'h00, 1'b0);
        seed = lfsr(seed);
        press_release(seed[6:0], 7'h00, 1'b0);
        end_of_test;
    end

    initial begin
        repeat (110000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
endmodule
